/* File: std_timer_pkg.sv */
// Package with register map, field positions and types for the standard timer core
package std_timer_pkg;
  // Register offsets, one byte register each
  localparam logic [2:0] OFF_CONTROL_A = 3'h0;
  localparam logic [2:0] OFF_CONTROL_B = 3'h1;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFF_CMPA_LOW = 3'h4;
  localparam logic [2:0] OFF_CMPA_HIGH = 3'h5;
  // Reset values and counter maximum
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [9:0] COUNT_RESET = 10'h000;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  // Clock select codes
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_TBC_A = 3'h4;
  localparam logic [2:0] CLK_TBC_B = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  // Prescaler terminal counts
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  // Operating modes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  // Pin function codes
  localparam logic [1:0] PIN_FN_0 = 2'h0;
  localparam logic [1:0] PIN_FN_1 = 2'h1;
  localparam logic [1:0] PIN_FN_2 = 2'h2;
  localparam logic [1:0] PIN_FN_3 = 2'h3;
  // Control A layout
  typedef struct packed {
    logic pause_control;
    logic [2:0] count_clock_select;
    logic counter_on;
    logic [2:0] period_compare_bits;
  } control_a_t;
  // Control B layout
  typedef struct packed {
    logic [1:0] op_mode_select;
    logic [1:0] pin_function_select;
    logic output_level_control;
    logic output_invert;
    logic period_duty_swap;
    logic clear_source_select;
  } control_b_t;
  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // Timer events
  typedef struct packed {
    logic match_a;
    logic match_p;
    logic capture;
  } timer_events_t;
endpackage

/* File: std_timer_core.sv */
// Standard 10-bit timer core with byte register port
// How it works
// R1: Ten-bit up counter, one step per tick
// R2: P compares bits 9..7, A all bits
// R3: Software clears counter only via enable rise
// R4: Pause freezes counter, resume keeps value
// R5: Clock select picks prescaled, timebase, pin edge
// R6: Off holds value; on rise clears, starts
// R7: Enable rise loads output initial level
// R8: Period code times 128; zero means 1024
// R9: Two-bit mode field selects operating mode
// R10: Software stops timer before mode change
// R11: Compare mode: A match clears/sets/toggles pin
// R12: PWM mode: inactive, active, PWM, pulse
// R13: Capture mode: rise, fall, both, off
// R14: Match equal to current level: no change
// R15: Software stops timer before PWM function change
// R16: Output control sets initial or active level
// R17: Invert bit flips the output pin
// R18: Swap bit exchanges period and duty roles
// R19: Clear on A match, else P/overflow
// R20: Clear source ignored in PWM, capture
// R21: Automatic clears raise timer event pulses
// R22: Timer/counter mode leaves pin undefined
// R23: Counter read-only pair, A read/write pair
// R24: Low bytes staged through one holding buffer
// R25: Zero A in compare: overflow, no A flag; with A clear the code matches at count 0 and holds the counter at 0
// R26: External clock pin edge makes count pulse
`timescale 1ns/1ps
module std_timer_core
  import std_timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire logic high_internal_clock_tick,
  input wire logic timebase_clock_tick,
  input wire logic ext_count_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output timer_events_t events,
  output logic [9:0] capture_value
);

  control_a_t ctl_a_reg;
  control_b_t ctl_b_reg;
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic [9:0] cmpa_reg;
  logic [7:0] hold_reg;
  logic [7:0] rdata_next;
  logic [5:0] sys_div_reg;
  logic [5:0] high_div_reg;
  logic [1:0] ext_sync_reg;
  logic ext_last_reg;
  logic [1:0] cap_sync_reg;
  logic cap_last_reg;
  logic on_last_reg;
  logic out_level_reg;
  logic out_level_next;
  logic pulse_done_reg;
  timer_events_t events_next;

  // Register decode
  wire wr_a = req.wr && req.addr == OFF_CONTROL_A;
  wire wr_b = req.wr && req.addr == OFF_CONTROL_B;
  wire wr_cmpa_lo = req.wr && req.addr == OFF_CMPA_LOW;
  wire wr_cmpa_hi = req.wr && req.addr == OFF_CMPA_HIGH;
  wire rd_count_hi = req.rd && req.addr == OFF_COUNT_HIGH;
  wire rd_cmpa_hi = req.rd && req.addr == OFF_CMPA_HIGH;
  wire control_a_t wr_a_val = req.wdata;
  wire on_rise = ctl_a_reg.counter_on && !on_last_reg;
  wire [1:0] mode = ctl_b_reg.op_mode_select;
  wire [1:0] pin_fn = ctl_b_reg.pin_function_select;

  // Prescaler taps and pin edges
  wire ext_rise = ext_sync_reg[1] && !ext_last_reg;
  wire ext_fall = !ext_sync_reg[1] && ext_last_reg;
  wire cap_rise = cap_sync_reg[1] && !cap_last_reg;
  wire cap_fall = !cap_sync_reg[1] && cap_last_reg;
  wire div4_tick = sys_div_reg[1:0] == DIV4_LAST[1:0];
  wire div16_tick = high_internal_clock_tick && high_div_reg[3:0] == DIV16_LAST[3:0];
  wire div64_tick = high_internal_clock_tick && high_div_reg == DIV64_LAST;

  // Clock selection
  logic tick_sel;
  always_comb
  begin
    unique case (ctl_a_reg.count_clock_select)
      CLK_SYS_DIV4: tick_sel = div4_tick;
      CLK_SYS: tick_sel = 1'b1;
      CLK_HIGH_DIV16: tick_sel = div16_tick;
      CLK_HIGH_DIV64: tick_sel = div64_tick;
      CLK_TBC_A, CLK_TBC_B: tick_sel = timebase_clock_tick;
      CLK_EXT_RISE: tick_sel = ext_rise; // see R26
      CLK_EXT_FALL: tick_sel = ext_fall; // see R26
    endcase
  end // see R5

  // Counting is gated by on, pause and the enable edge
  wire run = ctl_a_reg.counter_on && !ctl_a_reg.pause_control && !on_rise; // see R4 see R6
  wire tick = run && tick_sel;

  // Comparators
  // P matches on the tick that would carry bits 9..7 up to the code
  wire hit_p = count_reg == {ctl_a_reg.period_compare_bits - 3'h1, 7'h7f}
    && ctl_a_reg.period_compare_bits != 3'h0; // see R2
  wire hit_ovf = count_reg == COUNT_MAX;
  wire hit_a = count_reg == cmpa_reg; // see R2
  wire pwm_mode = mode == MODE_PWM;
  wire cmp_like = mode == MODE_COMPARE || mode == MODE_TIMER;
  // Period end: 3-bit code spans code*128 ticks, zero spans 1024
  wire p_end = ctl_a_reg.period_compare_bits == 3'h0 ? hit_ovf : hit_p; // see R8
  wire a_end = hit_a || (cmpa_reg == 10'h000 && hit_ovf);
  wire clr_by_a = cmp_like ? ctl_b_reg.clear_source_select
    : (pwm_mode && ctl_b_reg.period_duty_swap); // see R19 see R20 see R18
  wire clear_now = tick && (clr_by_a ? a_end : p_end);
  wire a_flag = tick && hit_a && !(cmp_like && cmpa_reg == 10'h000); // see R25
  wire p_flag = tick && p_end && !(cmp_like && ctl_b_reg.clear_source_select); // see R21

  // Counter next value
  always_comb
  begin
    count_next = count_reg;
    if (on_rise)
      count_next = COUNT_RESET; // see R3 see R6
    else if (clear_now)
      count_next = COUNT_RESET; // see R19
    else if (tick)
      count_next = count_reg + 10'h001; // see R1
  end

  // Duty compare for PWM, with swap of roles
  wire [9:0] duty_val = ctl_b_reg.period_duty_swap
    ? {ctl_a_reg.period_compare_bits, 7'h00} : cmpa_reg; // see R18
  wire duty_full = !ctl_b_reg.period_duty_swap && ctl_a_reg.period_compare_bits != 3'h0
    && cmpa_reg >= {ctl_a_reg.period_compare_bits, 7'h00};
  wire pwm_active = duty_full || (count_reg < duty_val)
    || (ctl_b_reg.period_duty_swap && ctl_a_reg.period_compare_bits == 3'h0);
  wire oc = ctl_b_reg.output_level_control;

  // Output level before polarity
  always_comb
  begin
    out_level_next = out_level_reg;
    if (on_rise)
      out_level_next = oc; // see R7 see R16
    else if (mode == MODE_COMPARE && a_flag)
    begin
      unique case (pin_fn)
        PIN_FN_0: out_level_next = out_level_reg;
        PIN_FN_1: out_level_next = 1'b0; // see R14
        PIN_FN_2: out_level_next = 1'b1; // see R14
        PIN_FN_3: out_level_next = !out_level_reg;
      endcase
    end // see R11
    else if (pwm_mode)
    begin
      unique case (pin_fn)
        PIN_FN_0: out_level_next = !oc;
        PIN_FN_1: out_level_next = oc;
        PIN_FN_2: out_level_next = pwm_active ? oc : !oc;
        PIN_FN_3: out_level_next = (pulse_done_reg || a_flag) ? !oc : out_level_reg;
      endcase
    end // see R12 see R16
  end

  // Capture edge selection
  logic cap_hit;
  always_comb
  begin
    unique case (pin_fn)
      PIN_FN_0: cap_hit = cap_rise;
      PIN_FN_1: cap_hit = cap_fall;
      PIN_FN_2: cap_hit = cap_rise || cap_fall;
      PIN_FN_3: cap_hit = 1'b0;
    endcase
  end // see R13
  wire cap_event = mode == MODE_CAPTURE && ctl_a_reg.counter_on && cap_hit;

  // Events toward interrupt logic
  always_comb
  begin
    events_next.match_a = a_flag;
    events_next.match_p = p_flag;
    events_next.capture = cap_event;
  end // see R21

  // Read data mux
  always_comb
  begin
    rdata_next = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        OFF_CONTROL_A: rdata_next = ctl_a_reg;
        OFF_CONTROL_B: rdata_next = ctl_b_reg;
        OFF_COUNT_LOW, OFF_CMPA_LOW: rdata_next = hold_reg; // see R24
        OFF_COUNT_HIGH: rdata_next = {6'h00, count_reg[9:8]}; // see R23
        OFF_CMPA_HIGH: rdata_next = {6'h00, cmpa_reg[9:8]}; // see R23
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Control registers and enable edge tracking
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctl_a_reg <= CONTROL_RESET;
      ctl_b_reg <= CONTROL_RESET;
      on_last_reg <= 1'b0;
    end
    else
    begin
      if (wr_a)
        ctl_a_reg <= wr_a_val;
      if (wr_b)
        ctl_b_reg <= req.wdata; // see R9
      on_last_reg <= ctl_a_reg.counter_on;
    end
  end

  // Compare A pair and holding buffer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmpa_reg <= COUNT_RESET;
      hold_reg <= 8'h00;
    end
    else
    begin
      if (wr_cmpa_hi)
        cmpa_reg <= {req.wdata[1:0], hold_reg}; // see R24
      if (wr_cmpa_lo)
        hold_reg <= req.wdata; // see R24
      else if (rd_count_hi)
        hold_reg <= count_reg[7:0]; // see R24
      else if (rd_cmpa_hi)
        hold_reg <= cmpa_reg[7:0]; // see R24
    end
  end

  // Counter, prescalers and pin sampling
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_reg <= COUNT_RESET;
      sys_div_reg <= 6'h00;
      high_div_reg <= 6'h00;
      ext_sync_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      cap_sync_reg <= 2'h0;
      cap_last_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      sys_div_reg <= sys_div_reg + 6'h01;
      if (high_internal_clock_tick)
        high_div_reg <= high_div_reg + 6'h01;
      ext_sync_reg <= {ext_sync_reg[0], ext_count_clock_pin}; // see R26
      ext_last_reg <= ext_sync_reg[1];
      cap_sync_reg <= {cap_sync_reg[0], capture_input_pin};
      cap_last_reg <= cap_sync_reg[1];
    end
  end

  // Output, capture and event registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      out_level_reg <= 1'b0;
      pulse_done_reg <= 1'b0;
      timer_output_pin <= 1'b0;
      capture_value <= COUNT_RESET;
      events <= '0;
      rdata <= 8'h00;
    end
    else
    begin
      out_level_reg <= out_level_next;
      if (on_rise)
        pulse_done_reg <= 1'b0;
      else if (a_flag)
        pulse_done_reg <= 1'b1;
      // Timer mode drives the raw level; any value is acceptable there
      timer_output_pin <= (mode == MODE_TIMER) ? out_level_next
        : out_level_next ^ ctl_b_reg.output_invert; // see R17 see R22
      if (cap_event)
        capture_value <= count_reg;
      events <= events_next;
      rdata <= rdata_next;
    end
  end

  // Assertions
  a_count_up_step: assert property (@(posedge clock) disable iff (rst) // see R1
    tick && !clear_now && !on_rise |=> count_reg == $past(count_reg) + 10'h001)
    else $error("counter did not step by one");
  a_pause_holds: assert property (@(posedge clock) disable iff (rst) // see R4
    ctl_a_reg.pause_control && !on_rise |=> $stable(count_reg))
    else $error("counter moved while paused");
  a_on_rise_clears: assert property (@(posedge clock) disable iff (rst) // see R3
    on_rise |=> count_reg == 10'h000)
    else $error("enable rise did not clear counter");
  a_off_holds: assert property (@(posedge clock) disable iff (rst) // see R6
    !ctl_a_reg.counter_on && !on_rise |=> $stable(count_reg))
    else $error("counter moved while off");
  a_init_level: assert property (@(posedge clock) disable iff (rst) // see R7
    on_rise && mode == MODE_COMPARE |=> out_level_reg == $past(oc))
    else $error("output not set to initial level");
  a_ab_clear: assert property (@(posedge clock) disable iff (rst) // see R19
    tick && cmp_like && ctl_b_reg.clear_source_select && hit_a && !on_rise
    |=> count_reg == 10'h000)
    else $error("A match did not clear counter");
  a_no_p_flag: assert property (@(posedge clock) disable iff (rst) // see R19
    cmp_like && ctl_b_reg.clear_source_select |=> !events.match_p)
    else $error("P flag raised with A clear");
  a_zero_a_flag: assert property (@(posedge clock) disable iff (rst) // see R25
    cmp_like && cmpa_reg == 10'h000 |=> !events.match_a)
    else $error("A flag raised with zero compare");
  a_hold_commit: assert property (@(posedge clock) disable iff (rst) // see R24
    wr_cmpa_hi |=> cmpa_reg == {$past(req.wdata[1:0]), $past(hold_reg)})
    else $error("high write did not commit pair");
  a_pin_polarity: assert property (@(posedge clock) disable iff (rst) // see R17
    mode != MODE_TIMER && $past(mode) != MODE_TIMER
    |-> timer_output_pin == (out_level_reg ^ $past(ctl_b_reg.output_invert)))
    else $error("output polarity wrong");
  a_p_period_clear: assert property (@(posedge clock) disable iff (rst) // see R8
    tick && !clr_by_a && p_end && !on_rise |=> count_reg == 10'h000)
    else $error("period end did not clear counter");
  a_cmp_pin_hold: assert property (@(posedge clock) disable iff (rst) // see R11
    mode == MODE_COMPARE && !a_flag && !on_rise |=> $stable(out_level_reg))
    else $error("compare output moved without A match");
  a_pwm_fixed_level: assert property (@(posedge clock) disable iff (rst) // see R12
    pwm_mode && pin_fn == PIN_FN_1 && !on_rise |=> out_level_reg == $past(oc))
    else $error("active level not held");
  a_capture_off: assert property (@(posedge clock) disable iff (rst) // see R13
    mode == MODE_CAPTURE && pin_fn == PIN_FN_3 |=> !events.capture)
    else $error("capture taken while disabled");
  a_ext_edge_only: assert property (@(posedge clock) disable iff (rst) // see R26
    ctl_a_reg.count_clock_select == CLK_EXT_RISE && !ext_rise && !on_rise
    |=> $stable(count_reg))
    else $error("counter moved without pin edge");
endmodule

/* File: timer_pins_model.sv */
// Behavioural model of the clock sources and pins around the timer
`timescale 1ns/1ps
module timer_pins_model (
  input wire logic clock,
  output logic high_internal_clock_tick,
  output logic timebase_clock_tick,
  output logic ext_count_clock_pin,
  output logic capture_input_pin
);
  logic [3:0] div_reg = 4'h0;
  // Free-running internal clock ticks
  always @(posedge clock)
    div_reg <= div_reg + 4'h1;
  assign high_internal_clock_tick = (div_reg[1:0] == 2'h3);
  assign timebase_clock_tick = (div_reg == 4'hf);
  // Pins idle low until a pulse is asked for
  initial
  begin
    ext_count_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // Each level is held well past the two-flop synchroniser
  task automatic pulse(input logic cap, input int n);
    repeat (n)
    begin
      if (cap)
        capture_input_pin <= 1'b1;
      else
        ext_count_clock_pin <= 1'b1;
      repeat (6) @(posedge clock);
      capture_input_pin <= 1'b0;
      ext_count_clock_pin <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench for the standard timer core
`timescale 1ns/1ps
module tb;
  import std_timer_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic hi_tick, tbc_tick, ext_pin, cap_pin, pin;
  timer_events_t events;
  logic [9:0] cap_val;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Clock and cycle ceiling
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      num_errors++;
      conclude();
    end
  end
  std_timer_core i_dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
    .high_internal_clock_tick(hi_tick), .timebase_clock_tick(tbc_tick),
    .ext_count_clock_pin(ext_pin), .capture_input_pin(cap_pin),
    .timer_output_pin(pin), .events(events), .capture_value(cap_val));
  timer_pins_model i_pins (.clock(clock), .high_internal_clock_tick(hi_tick),
    .timebase_clock_tick(tbc_tick), .ext_count_clock_pin(ext_pin),
    .capture_input_pin(cap_pin));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Register bus cycles, entered just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '0;
    #1 v = rdata;
    @(posedge clock);
  endtask
  // High byte first, so the low byte comes from the holding buffer
  task automatic rd10(input logic [2:0] hi, output logic [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(hi, h);
    rd(hi - 3'h1, l);
    chk(h[7:2], 6'h00);
    v = {h[1:0], l};
  endtask
  // Waits for an event pulse, then counts cycles to the next one
  task automatic gap(input int b, output int n, output logic p1, output logic p2);
    n = 0;
    while (events[b] !== 1'b1)
      @(posedge clock);
    p1 = pin;
    do
    begin
      n++;
      @(posedge clock);
    end
    while (events[b] !== 1'b1 && n < 4000);
    p2 = pin;
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd(OFF_CONTROL_B, v);
    chk(v, CONTROL_RESET);
    rd(3'h6, v);
    chk(v, 8'h00);
    wr(OFF_CMPA_LOW, 8'h34);
    wr(OFF_CMPA_HIGH, 8'h01);
    wr(OFF_CMPA_LOW, 8'h77);
    rd(OFF_CMPA_HIGH, v);
    chk(v, 8'h01);
    rd(OFF_CMPA_LOW, v);
    chk(v, 8'h34);
    $display("registers done");
  endtask
  task automatic t_pause();
    logic [9:0] v1;
    logic [9:0] v2;
    wr(OFF_CONTROL_A, 8'h18);
    repeat (20) @(posedge clock);
    wr(OFF_CONTROL_A, 8'h98);
    rd10(OFF_COUNT_HIGH, v1);
    wr(OFF_COUNT_LOW, 8'hff);
    wr(OFF_COUNT_HIGH, 8'hff);
    wr(OFF_CONTROL_A, 8'h10);
    rd10(OFF_COUNT_HIGH, v2);
    chk(v2, v1);
    chk(v1 inside {[10'h00f:10'h028]}, 1'b1);
    $display("pause done");
  endtask
  task automatic t_ext(input logic [2:0] s);
    logic [9:0] v;
    wr(OFF_CONTROL_A, {1'b0, s, 4'h0});
    wr(OFF_CONTROL_A, {1'b0, s, 4'h8});
    i_pins.pulse(1'b0, 5);
    repeat (4) @(posedge clock);
    rd10(OFF_COUNT_HIGH, v);
    chk(v, 10'h005);
    $display("external clock done");
  endtask
  task automatic t_period(input logic [2:0] c, input logic [1:0] m);
    int n;
    logic p1;
    logic p2;
    wr(OFF_CONTROL_A, 8'h10);
    wr(OFF_CONTROL_B, {m, 6'h00});
    wr(OFF_CONTROL_A, {4'h1, 1'b1, c});
    gap(1, n, p1, p2);
    chk(16'(n), (c == 3'h0) ? 16'h0400 : {6'h00, c, 7'h00});
    $display("period done");
  endtask
  task automatic t_cmp(input logic [1:0] fn, input logic oc, inv, e1, e2);
    int n;
    logic p1;
    logic p2;
    wr(OFF_CONTROL_A, 8'h10);
    wr(OFF_CONTROL_B, {MODE_COMPARE, fn, oc, inv, 2'h1});
    wr(OFF_CMPA_LOW, 8'h10);
    wr(OFF_CMPA_HIGH, 8'h00);
    wr(OFF_CONTROL_A, 8'h18);
    @(posedge clock);
    chk(pin, oc ^ inv);
    gap(2, n, p1, p2);
    chk(16'(n), 16'h0011);
    chk({p1, p2}, {e1, e2});
    $display("compare done");
  endtask
  // Capture starts with the enable; rise seen at count 2, fall at count 8
  task automatic t_cap(input logic [1:0] fn, input logic [15:0] exp, input logic [9:0] cv);
    int k;
    k = 0;
    wr(OFF_CONTROL_A, 8'h10);
    wr(OFF_CONTROL_B, {MODE_CAPTURE, fn, 4'h0});
    wr(OFF_CONTROL_A, 8'h18);
    fork
      i_pins.pulse(1'b1, 1);
      repeat (40)
      begin
        @(posedge clock);
        if (events.capture === 1'b1)
          k++;
      end
    join
    chk(16'(k), exp);
    chk(cap_val, cv);
    $display("capture done");
  endtask
  // Internal clock selects: count over 129 cycles lies in a rate window
  task automatic t_rate(input logic [2:0] s, input logic [9:0] lo, input logic [9:0] hi);
    logic [9:0] v;
    wr(OFF_CONTROL_A, {1'b0, s, 4'h0});
    wr(OFF_CONTROL_A, {1'b0, s, 4'h8});
    repeat (128) @(posedge clock);
    wr(OFF_CONTROL_A, {1'b1, s, 4'h8});
    rd10(OFF_COUNT_HIGH, v);
    chk(v inside {[lo:hi]}, 1'b1);
    $display("clock rate done");
  endtask
  // PWM, period 128, duty 32, active high; counts high samples over one period
  task automatic t_pwm(input logic [1:0] fn, input logic [15:0] exp);
    int k;
    k = 0;
    wr(OFF_CONTROL_A, 8'h10);
    wr(OFF_CONTROL_B, {MODE_PWM, fn, 4'h8});
    wr(OFF_CMPA_LOW, 8'h20);
    wr(OFF_CMPA_HIGH, 8'h00);
    wr(OFF_CONTROL_A, 8'h19);
    repeat (8) @(posedge clock);
    repeat (128)
    begin
      @(posedge clock);
      if (pin === 1'b1)
        k++;
    end
    chk(16'(k), exp);
    $display("pwm done");
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_pause();
    t_ext(CLK_EXT_RISE);
    t_ext(CLK_EXT_FALL);
    t_period(3'h1, MODE_COMPARE);
    t_period(3'h3, MODE_TIMER);
    t_period(3'h0, MODE_COMPARE);
    t_cmp(PIN_FN_3, 1'b0, 1'b0, 1'b1, 1'b0);
    t_cmp(PIN_FN_2, 1'b1, 1'b0, 1'b1, 1'b1);
    t_cmp(PIN_FN_1, 1'b0, 1'b1, 1'b1, 1'b1);
    t_cmp(PIN_FN_2, 1'b0, 1'b1, 1'b0, 1'b0);
    t_cap(PIN_FN_0, 16'h0001, 10'h002);
    t_cap(PIN_FN_1, 16'h0001, 10'h008);
    t_cap(PIN_FN_2, 16'h0002, 10'h008);
    t_cap(PIN_FN_3, 16'h0000, 10'h008);
    t_pwm(PIN_FN_0, 16'h0000);
    t_pwm(PIN_FN_1, 16'h0080);
    t_pwm(PIN_FN_2, 16'h0020);
    t_pwm(PIN_FN_3, 16'h0019);
    t_rate(CLK_SYS_DIV4, 10'h020, 10'h021);
    t_rate(CLK_HIGH_DIV16, 10'h002, 10'h003);
    t_rate(CLK_HIGH_DIV64, 10'h000, 10'h001);
    t_rate(CLK_TBC_B, 10'h008, 10'h009);
    conclude();
  end
endmodule
